// ==== design/monitor_pkg.sv ====
// Constants shared by the cell monitor control register bank.
// Behaviour
// (R1) Converter powered only around a requested conversion unless always-on is set.
// (R2) Temperature select code picks none, first, second or both inputs.
// (R3) Auxiliary analog select adds the general-purpose input to the sequence.
// (R4) Cell range codes 0-5 select cells one to N; others cell one only.
// (R5) Supply switch bit connects the auxiliary pin to the 5 V regulator.
// (R6) Drive bit 0 pulls the open-drain pin low; level bit reads the pin.
// (R7) Low power disables comparators; wake waits 1 ms before monitoring resumes.
// (R8) Each return switch bit grounds its temperature input negative side.
// (R9) Six balance bits drive six balance outputs, all reset low.
// (R10) Balance active time limited in seconds or minutes; zero prevents balancing.
// (R11) Conversion go starts a sequence, self-clears when it begins, reads zero.
// (R12) Unlock key required for protected writes; reads zero; any write clears it.
// (R13) Refresh key reloads protected registers; unlock clears when reload ends.
// (R14) Frames answer at own node id, or broadcast when an id is assigned.
// (R15) Assigned flag resets low and is mirrored inverted as address request.
// (R16) Soft reset key performs a full reset; other values ignored.
// (R17) Two-key sequence enters debug pass-through; other writes cancel; zero leaves.
// (R18) Debug mode drives upper clock and data pins as copies of lower link.
// (R19) OTP key opens a write window closed by the next access.
// (R20) Conversion speed code selects roughly 3, 6, 12 or 24 microseconds.
// (R21) Source select picks external inputs or pack pin; reference select bandgap or 5 V.
// (R22) Series cell count masks faults on unused upper cells.
// (R23) Active balance outputs drop low when the time limit expires.
// (R24) Host writes zero to unused bits and only defined key codes.
package monitor_pkg;
	// Register offsets
	localparam logic [7:0] OFF_PARITY_B = 8'h25;
	localparam logic [7:0] OFF_CONVERSION_GO_SETUP = 8'h30;
	localparam logic [7:0] OFF_PIN_SLEEP = 8'h31;
	localparam logic [7:0] OFF_BAL_EN = 8'h32;
	localparam logic [7:0] OFF_BAL_TIME = 8'h33;
	localparam logic [7:0] OFF_CONVERSION_GO_TRIG = 8'h34;
	localparam logic [7:0] OFF_UNLOCK = 8'h3a;
	localparam logic [7:0] OFF_NODE_ID = 8'h3b;
	localparam logic [7:0] OFF_SOFT_RST = 8'h3c;
	localparam logic [7:0] OFF_DEBUG_SEL = 8'h3d;
	localparam logic [7:0] OFF_OTP_EN = 8'h3f;
	localparam logic [7:0] OFF_FUNC_CFG = 8'h40;
	localparam logic [3:0] PROT_GROUP_HI = 4'h4;
	// Keys
	localparam logic [7:0] KEY_UNLOCK = 8'h35;
	localparam logic [7:0] KEY_REFRESH = 8'h27;
	localparam logic [7:0] KEY_SOFT_RST = 8'ha5;
	localparam logic [7:0] KEY_DEBUG_1 = 8'ha4;
	localparam logic [7:0] KEY_DEBUG_2 = 8'h25;
	localparam logic [7:0] KEY_OTP = 8'h91;
	localparam logic [7:0] KEY_NONE = 8'h00;
	localparam logic [5:0] ADDR_BROADCAST = 6'h3f;
	// Field positions
	localparam int POS_ADC_ON = 6;
	localparam int POS_TEMP_SEL = 4;
	localparam int POS_AUX_SEL = 3;
	localparam int POS_AUX_SW = 7;
	localparam int POS_GP_DRIVE = 6;
	localparam int POS_GP_LEVEL = 5;
	localparam int POS_SLEEP = 2;
	localparam int POS_MINUTES = 7;
	localparam int POS_ID_FLAG = 7;
	localparam int POS_SPEED = 6;
	localparam int POS_REF_SEL = 5;
	localparam int POS_SRC_SEL = 4;
	localparam int POS_CELL_CNT = 2;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_PIN_SLEEP = 8'h40;
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int REF_SETTLE_US = 10;
	localparam int SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;
	localparam int WAKE_TIME_US = 1000;
	localparam int WAKE_CYC = WAKE_TIME_US * CLK_MHZ;
	localparam int SECOND_CYC = 1000000 * CLK_MHZ;
	localparam int MINUTE_SECONDS = 60;
	// Conversion sequencer states
	typedef enum logic [3:0] {
		C_IDLE = 4'b0001,
		C_WARM = 4'b0010,
		C_RUN = 4'b0100,
		C_WAIT = 4'b1000
	} conversion_go_state_t;
endpackage : monitor_pkg

// ==== design/pin_sync.sv ====
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule : pin_sync

// ==== design/balance_timer.sv ====
// Balance output safety timer in seconds or minutes.
`timescale 1ns/1ps
module balance_timer #(
	parameter int SEC_CYC = 40000000,
	parameter int MIN_SEC = 60
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Settings
	input wire logic [5:0] balanceReq,
	input wire logic [5:0] timeLimit,
	input wire logic useMinutes,
	// Results
	output logic [5:0] balanceOut,
	output logic expired
);
	logic [25:0] preCnt_q;
	logic [5:0] secCnt_q;
	logic [5:0] units_q;
	logic unitTick;
	logic secTick;

	assign secTick = (preCnt_q == 26'(SEC_CYC - 1));
	assign unitTick = secTick && (!useMinutes || secCnt_q == 6'(MIN_SEC - 1));
	// One shared limit from the moment any output becomes active
	assign expired = (balanceReq != 6'h00) && (units_q >= timeLimit); // R23

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			preCnt_q <= '0;
			secCnt_q <= '0;
			units_q <= '0;
		end else if (balanceReq == 6'h00) begin
			preCnt_q <= '0;
			secCnt_q <= '0;
			units_q <= '0;
		end else begin
			preCnt_q <= secTick ? 26'h0 : preCnt_q + 26'h1;
			if (secTick) begin
				secCnt_q <= (unitTick || useMinutes == 1'b0) ? 6'h00 : secCnt_q + 6'h01;
			end
			if (unitTick && !expired) begin
				units_q <= units_q + 6'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			balanceOut <= '0;
		end else begin
			balanceOut <= (timeLimit == 6'h00 || expired) ? 6'h00 : balanceReq; // R10
		end
	end
endmodule : balance_timer

// ==== design/monitor_control_register_bank.sv ====
// Control register bank of a stackable cell monitor, reached over SPI.
`timescale 1ns/1ps
module monitor_control_register_bank
	import monitor_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC,
	parameter int SEC_CYCLES = SECOND_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// SPI from the host side
	input wire logic spiCsN,
	input wire logic spiSclk,
	input wire logic spiSdi,
	output logic spiSdo,
	output logic spiSdoOeN,
	// Lower link and upper pass-through pins
	input wire logic lowerLinkClock,
	input wire logic lowerLinkDataIn,
	output logic upperSclkOut,
	output logic upperSclkOeN,
	output logic upperSdiOut,
	output logic upperSdiOeN,
	// Open-drain general pin
	input wire logic gpPinIn,
	output logic gpPinOut,
	output logic gpPinOeN,
	// Converter control
	output logic adcPowerOn,
	output logic convStart,
	input wire logic convDone,
	output logic [5:0] cellSelMask,
	output logic [1:0] tempInputSel,
	output logic auxAnalogSel,
	output logic [1:0] convSpeed,
	output logic analogSrcPack,
	output logic analogRefReg,
	// Analog switches and protection
	output logic supplySwitchOn,
	output logic lowPower,
	output logic comparatorsOn,
	output logic [1:0] thermReturnSw,
	output logic [5:0] cellFaultEnable,
	output logic [5:0] balanceOut,
	// OTP and system
	output logic addrUnassigned,
	output logic otpWriteWindow,
	output logic otpReloadReq,
	input wire logic otpReloadDone,
	input wire logic [7:0] otpFuncConfig,
	input wire logic [3:0] parityResultB,
	output logic softResetPulse
);
	logic csS, sclkS, sdiS, gpS, lowClkS, lowDatS;
	logic sclkPrev_q, csPrev_q;
	logic [4:0] bitCnt_q;
	logic [7:0] rxShift_q, txShift_q, hdr_q, regAddr_q;
	logic sclkRise, sclkFall, frameStart, byteDone, wrStb, addressed;
	logic [7:0] wrData;
	logic [7:0] convSetup_q, cbTime_q, unlock_q, debugKey_q, funcCfg_q;
	logic auxSw_q, gpDrive_q, sleep_q;
	logic [1:0] tsw_q;
	logic [5:0] balance_q, nodeId_q;
	logic idFlag_q, convGo_q, debugArm_q, debugMode_q, otpWin_q, reloadBusy_q;
	logic softRst_q, balExpired;
	logic [15:0] wakeCnt_q;
	logic [11:0] warmCnt_q;
	conversion_go_state_t convState_q;

	pin_sync #(.WIDTH(6)) inSync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.asyncIn({spiCsN, spiSclk, spiSdi, gpPinIn, lowerLinkClock, lowerLinkDataIn}),
		.syncOut({csS, sclkS, sdiS, gpS, lowClkS, lowDatS})
	);

	function automatic logic [5:0] cellRange(input logic [2:0] code);
		unique case (code)
			3'd0: cellRange = 6'h01;
			3'd1: cellRange = 6'h03;
			3'd2: cellRange = 6'h07;
			3'd3: cellRange = 6'h0f;
			3'd4: cellRange = 6'h1f;
			3'd5: cellRange = 6'h3f;
			default: cellRange = 6'h01;
		endcase
	endfunction : cellRange

	function automatic logic [5:0] seriesMask(input logic [1:0] code);
		unique case (code)
			2'd0: seriesMask = 6'h3f;
			2'd1: seriesMask = 6'h1f;
			2'd2: seriesMask = 6'h0f;
			2'd3: seriesMask = 6'h07;
		endcase
	endfunction : seriesMask

	// SPI framing: header {node id, write}, register, then data byte
	assign sclkRise = !csS && sclkS && !sclkPrev_q;
	assign sclkFall = !csS && !sclkS && sclkPrev_q;
	assign frameStart = csPrev_q && !csS;
	assign byteDone = sclkRise && (bitCnt_q[2:0] == 3'd7);
	assign wrData = {rxShift_q[6:0], sdiS};
	assign addressed = (hdr_q[7:2] == nodeId_q[5:0])
		|| (hdr_q[7:2] == ADDR_BROADCAST && idFlag_q); // R14
	assign wrStb = byteDone && (bitCnt_q[4:3] == 2'd2) && hdr_q[0] && addressed;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev_q <= 1'b0;
			csPrev_q <= 1'b0; // Synced select resets low; no false frame start
			bitCnt_q <= '0;
			rxShift_q <= '0;
			hdr_q <= '0;
			regAddr_q <= '0;
		end else begin
			sclkPrev_q <= sclkS;
			csPrev_q <= csS;
			if (csS) begin
				bitCnt_q <= '0;
			end else if (sclkRise) begin
				rxShift_q <= wrData;
				if (bitCnt_q != 5'd24) begin
					bitCnt_q <= bitCnt_q + 5'd1;
				end
				if (byteDone && bitCnt_q[4:3] == 2'd0) begin
					hdr_q <= wrData;
				end
				if (byteDone && bitCnt_q[4:3] == 2'd1) begin
					regAddr_q <= wrData;
				end
			end
		end
	end

	function automatic logic [7:0] readMux(input logic [7:0] a);
		unique case (a)
			OFF_PARITY_B: readMux = {4'h0, parityResultB};
			OFF_CONVERSION_GO_SETUP: readMux = convSetup_q;
			OFF_PIN_SLEEP: readMux = {auxSw_q, gpDrive_q, gpS, 2'b00, sleep_q, tsw_q}; // R6
			OFF_BAL_EN: readMux = {2'b00, balance_q};
			OFF_BAL_TIME: readMux = {cbTime_q[7], 1'b0, cbTime_q[5:0]};
			OFF_NODE_ID: readMux = {idFlag_q, 1'b0, nodeId_q};
			OFF_DEBUG_SEL: readMux = debugKey_q;
			OFF_OTP_EN: readMux = {7'h00, otpWin_q};
			OFF_FUNC_CFG: readMux = funcCfg_q;
			default: readMux = RST_BYTE; // Unlock, trigger and reset read zero
		endcase
	endfunction : readMux

	// Read data is loaded after the register byte, shifted on falling edges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txShift_q <= '0;
			spiSdoOeN <= 1'b1;
		end else begin
			if (byteDone && bitCnt_q[4:3] == 2'd1) begin
				txShift_q <= readMux(wrData);
				spiSdoOeN <= !(!hdr_q[0] && addressed);
			end else if (sclkFall && bitCnt_q[2:0] != 3'd0) begin
				txShift_q <= {txShift_q[6:0], 1'b0};
			end
			if (csS) begin
				spiSdoOeN <= 1'b1;
			end
		end
	end
	assign spiSdo = txShift_q[7];

	// Soft reset clears the whole bank on the cycle after the key
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			softRst_q <= 1'b0;
		end else begin
			softRst_q <= wrStb && regAddr_q == OFF_SOFT_RST && wrData == KEY_SOFT_RST; // R16
		end
	end
	assign softResetPulse = softRst_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			convSetup_q <= RST_BYTE;
			auxSw_q <= 1'b0;
			gpDrive_q <= RST_PIN_SLEEP[POS_GP_DRIVE];
			sleep_q <= 1'b0;
			tsw_q <= '0;
			balance_q <= '0;
			cbTime_q <= RST_BYTE;
			nodeId_q <= '0;
			idFlag_q <= 1'b0;
		end else if (softRst_q) begin
			convSetup_q <= RST_BYTE;
			auxSw_q <= 1'b0;
			gpDrive_q <= RST_PIN_SLEEP[POS_GP_DRIVE];
			sleep_q <= 1'b0;
			tsw_q <= '0;
			balance_q <= '0;
			cbTime_q <= RST_BYTE;
			nodeId_q <= '0;
			idFlag_q <= 1'b0; // R15
		end else begin
			if (balExpired) begin
				balance_q <= '0; // R23
			end
			if (wrStb) begin
				unique case (regAddr_q)
					OFF_CONVERSION_GO_SETUP: convSetup_q <= wrData;
					OFF_PIN_SLEEP: begin
						auxSw_q <= wrData[POS_AUX_SW];
						gpDrive_q <= wrData[POS_GP_DRIVE];
						sleep_q <= wrData[POS_SLEEP];
						tsw_q <= wrData[1:0];
					end
					OFF_BAL_EN: balance_q <= wrData[5:0];
					OFF_BAL_TIME: cbTime_q <= wrData;
					OFF_NODE_ID: begin
						nodeId_q <= wrData[5:0];
						idFlag_q <= wrData[POS_ID_FLAG];
					end
					default: ;
				endcase
			end
		end
	end

	// Unlock, refresh, protected writes and OTP window
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unlock_q <= RST_BYTE;
			funcCfg_q <= RST_BYTE;
			reloadBusy_q <= 1'b0;
			otpWin_q <= 1'b0;
		end else if (softRst_q) begin
			unlock_q <= RST_BYTE;
			funcCfg_q <= RST_BYTE;
			reloadBusy_q <= 1'b0;
			otpWin_q <= 1'b0;
		end else begin
			if (frameStart) begin
				otpWin_q <= 1'b0; // R19
			end
			if (reloadBusy_q && otpReloadDone) begin
				funcCfg_q <= otpFuncConfig;
				unlock_q <= RST_BYTE; // R13
				reloadBusy_q <= 1'b0;
			end
			if (wrStb) begin
				unlock_q <= RST_BYTE; // R12
				if (regAddr_q == OFF_UNLOCK) begin
					unlock_q <= wrData;
					reloadBusy_q <= (wrData == KEY_REFRESH); // R13
				end
				if (regAddr_q == OFF_FUNC_CFG && unlock_q == KEY_UNLOCK) begin
					funcCfg_q <= {wrData[7:1], 1'b0}; // R12
				end
				if (regAddr_q == OFF_OTP_EN) begin
					otpWin_q <= (wrData == KEY_OTP); // R19
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			otpReloadReq <= 1'b0;
		end else begin
			otpReloadReq <= wrStb && regAddr_q == OFF_UNLOCK && wrData == KEY_REFRESH;
		end
	end

	// Debug key sequence: only back-to-back writes count
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			debugKey_q <= RST_BYTE;
			debugArm_q <= 1'b0;
			debugMode_q <= 1'b0;
		end else if (softRst_q) begin
			debugKey_q <= RST_BYTE;
			debugArm_q <= 1'b0;
			debugMode_q <= 1'b0;
		end else if (wrStb) begin
			if (regAddr_q == OFF_DEBUG_SEL) begin
				debugKey_q <= wrData;
				debugArm_q <= (wrData == KEY_DEBUG_1); // R17
				if (wrData == KEY_DEBUG_2 && debugArm_q) begin
					debugMode_q <= 1'b1; // R17
				end else if (wrData == KEY_NONE) begin
					debugMode_q <= 1'b0;
				end
			end else begin
				debugArm_q <= 1'b0; // R17
			end
		end
	end

	// Pass-through copies the lower link; never enable this on the bottom device
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upperSclkOut <= 1'b0;
			upperSdiOut <= 1'b0;
			upperSclkOeN <= 1'b1;
			upperSdiOeN <= 1'b1;
		end else begin
			upperSclkOut <= lowClkS; // R18
			upperSdiOut <= lowDatS;
			upperSclkOeN <= !debugMode_q; // R18
			upperSdiOeN <= !debugMode_q;
		end
	end

	// Conversion sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			convState_q <= C_IDLE;
			convGo_q <= 1'b0;
			warmCnt_q <= '0;
		end else if (softRst_q) begin
			convState_q <= C_IDLE;
			convGo_q <= 1'b0;
			warmCnt_q <= '0;
		end else begin
			unique case (convState_q)
				C_IDLE: begin
					warmCnt_q <= '0;
					if (convGo_q) begin
						convState_q <= convSetup_q[POS_ADC_ON] ? C_RUN : C_WARM; // R1
					end
				end
				C_WARM: begin
					warmCnt_q <= warmCnt_q + 12'h001;
					if (warmCnt_q == 12'(SETTLE_CYC - 1)) begin
						convState_q <= C_RUN; // R1
					end
				end
				C_RUN: begin
					convGo_q <= 1'b0; // R11
					convState_q <= C_WAIT;
				end
				C_WAIT: begin
					if (convDone) begin
						convState_q <= C_IDLE;
					end
				end
			endcase
			if (wrStb && regAddr_q == OFF_CONVERSION_GO_TRIG && wrData[0]) begin
				convGo_q <= 1'b1; // R11
			end
		end
	end
	assign convStart = (convState_q == C_RUN);
	assign adcPowerOn = convSetup_q[POS_ADC_ON] || (convState_q != C_IDLE); // R1

	// Comparators stay off for a fixed time after leaving low power
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wakeCnt_q <= '0;
		end else if (sleep_q) begin
			wakeCnt_q <= 16'(WAKE_CYCLES); // R7
		end else if (wakeCnt_q != 16'h0000) begin
			wakeCnt_q <= wakeCnt_q - 16'h0001;
		end
	end
	assign comparatorsOn = !sleep_q && (wakeCnt_q == 16'h0000); // R7
	assign lowPower = sleep_q;

	balance_timer #(.SEC_CYC(SEC_CYCLES), .MIN_SEC(MINUTE_SECONDS)) balTimer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.balanceReq(balance_q),
		.timeLimit(cbTime_q[5:0]),
		.useMinutes(cbTime_q[POS_MINUTES]),
		.balanceOut(balanceOut), // R9
		.expired(balExpired)
	);

	assign cellSelMask = cellRange(convSetup_q[2:0]); // R4
	assign tempInputSel = convSetup_q[POS_TEMP_SEL +: 2]; // R2
	assign auxAnalogSel = convSetup_q[POS_AUX_SEL]; // R3
	assign convSpeed = funcCfg_q[POS_SPEED +: 2]; // R20
	assign analogSrcPack = funcCfg_q[POS_SRC_SEL]; // R21
	assign analogRefReg = funcCfg_q[POS_REF_SEL]; // R21
	assign cellFaultEnable = seriesMask(funcCfg_q[POS_CELL_CNT +: 2]); // R22
	assign supplySwitchOn = auxSw_q; // R5
	assign thermReturnSw = tsw_q; // R8
	assign gpPinOut = 1'b0;
	assign gpPinOeN = gpDrive_q; // R6
	assign addrUnassigned = !idFlag_q; // R15
	assign otpWriteWindow = otpWin_q;

	adc_power_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
		(!convSetup_q[POS_ADC_ON] && convState_q == C_IDLE) |-> !adcPowerOn)
		else $error("converter powered while idle in auto mode");
	warm_time_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
		(convState_q == C_WARM && warmCnt_q < 12'(SETTLE_CYC - 1)) |=> !convStart)
		else $error("conversion started before reference settled");
	conversion_go_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
		(convStart && !wrStb) |=> (!convGo_q && convState_q == C_WAIT))
		else $error("conversion go not cleared once conversion began");
	wake_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
		$fell(sleep_q) |-> !comparatorsOn [*8])
		else $error("comparators resumed without wake delay");
	unlock_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
		(wrStb && regAddr_q != OFF_UNLOCK) |=> unlock_q == RST_BYTE)
		else $error("unlock key survived another write");
	protect_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
		(wrStb && regAddr_q == OFF_FUNC_CFG && unlock_q != KEY_UNLOCK
		&& !(reloadBusy_q && otpReloadDone) && !softRst_q) |=> $stable(funcCfg_q))
		else $error("protected register written while locked");
	debug_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
		$rose(debugMode_q) |-> $past(debugArm_q))
		else $error("debug mode entered without first key");
	otp_close_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
		(frameStart && otpWin_q) |=> !otpWin_q)
		else $error("otp window stayed open across an access");
	balance_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
		(cbTime_q[5:0] == 6'h00) [*2] |-> balanceOut == 6'h00)
		else $error("balancing active with zero time limit");
endmodule : monitor_control_register_bank

// ==== verif/spi_host_model.sv ====
// Host controller model: three-byte SPI frames, mode 0, MSB first.
`timescale 1ns/1ps
module spi_host_model (
	// Clock
	input wire logic core_clk,
	// SPI pins
	output logic spiCsN,
	output logic spiSclk,
	output logic spiSdi,
	input wire logic spiSdo
);
	logic [5:0] nodeId = 6'h00;
	initial begin
		spiCsN = 1'b1;
		spiSclk = 1'b0;
		spiSdi = 1'b0;
	end
	// Four core cycles per half period give the 200 ns link clock
	task automatic half();
		repeat (4) @(posedge core_clk);
	endtask : half
	task automatic xfer(input logic wr, input logic [7:0] off, input logic [7:0] dat,
		output logic [7:0] rd);
		logic [23:0] sh;
		sh = {nodeId, 1'b0, wr, off, dat};
		rd = 8'h00;
		@(posedge core_clk);
		spiCsN <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spiSdi <= sh[i];
			half();
			// Read at the rising edge, before the device shifts
			if (i < 8)
				rd[i] = spiSdo;
			spiSclk <= 1'b1;
			half();
			spiSclk <= 1'b0;
		end
		half();
		spiCsN <= 1'b1;
		// Released line must not keep showing the last bit
		spiSdi <= ~sh[0];
		half();
	endtask : xfer
endmodule : spi_host_model

// ==== verif/monitor_control_register_bank_tb_top.sv ====
// Self-checking bench for the cell monitor control register bank.
`timescale 1ns/1ps
module monitor_control_register_bank_tb_top;
	import monitor_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOeN, sdoLine;
	logic lowerLinkClock = 1'b0;
	logic lowerLinkDataIn = 1'b0;
	logic upperSclkOut, upperSclkOeN, upperSdiOut, upperSdiOeN;
	logic gpExt = 1'b1;
	logic gpPinIn, gpPinOut, gpPinOeN, adcPowerOn, convStart, auxAnalogSel;
	logic convDone = 1'b0;
	logic [5:0] cellSelMask, cellFaultEnable, balanceOut;
	logic [1:0] tempInputSel, convSpeed, thermReturnSw;
	logic analogSrcPack, analogRefReg, supplySwitchOn, lowPower, comparatorsOn;
	logic addrUnassigned, otpWriteWindow, otpReloadReq, softResetPulse;
	logic otpReloadDone = 1'b0;
	logic [7:0] otpFuncConfig = 8'h5c;
	logic [3:0] parityResultB = 4'ha;
	logic linkRun = 1'b0;
	int err_count = 0;
	int num_checks = 0;
	int reloadCnt = 0;
	int softCnt = 0;
	// One-cycle pulses are counted so that a task can judge them later
	always @(posedge core_clk) begin
		reloadCnt <= reloadCnt + int'(otpReloadReq);
		softCnt <= softCnt + int'(softResetPulse);
	end
	// Pull-ups on the open-drain pin and the shared data-out line
	assign gpPinIn = gpExt & (gpPinOeN | gpPinOut);
	assign sdoLine = spiSdoOeN ? 1'b1 : spiSdo;
	always #12.5 core_clk = ~core_clk;
	// Link clock stands still unless pass-through traffic is wanted
	always #100 if (linkRun) begin
		lowerLinkClock <= ~lowerLinkClock;
		lowerLinkDataIn <= lowerLinkClock;
	end
	spi_host_model host_u (.core_clk, .spiCsN, .spiSclk, .spiSdi, .spiSdo(sdoLine));
	monitor_control_register_bank #(.WAKE_CYCLES(20), .SEC_CYCLES(40)) dut_u (
		.core_clk, .rst_n, .spiCsN, .spiSclk, .spiSdi, .spiSdo, .spiSdoOeN,
		.lowerLinkClock, .lowerLinkDataIn, .upperSclkOut, .upperSclkOeN, .upperSdiOut,
		.upperSdiOeN, .gpPinIn, .gpPinOut, .gpPinOeN, .adcPowerOn, .convStart, .convDone,
		.cellSelMask, .tempInputSel, .auxAnalogSel, .convSpeed, .analogSrcPack,
		.analogRefReg, .supplySwitchOn, .lowPower, .comparatorsOn, .thermReturnSw,
		.cellFaultEnable, .balanceOut, .addrUnassigned, .otpWriteWindow, .otpReloadReq,
		.otpReloadDone, .otpFuncConfig, .parityResultB, .softResetPulse
	);
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		host_u.xfer(1'b1, a, d, r);
		repeat (3) @(posedge core_clk);
	endtask : wr
	task automatic rx(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		host_u.xfer(1'b0, a, 8'h00, r);
		chk(nm, e, r);
	endtask : rx
	task automatic tReset();
		rx("idRst", OFF_NODE_ID, 8'h00);
		rx("unlockRst", OFF_UNLOCK, 8'h00);
		rx("parity", OFF_PARITY_B, 8'h0a);
		rx("pinRst", OFF_PIN_SLEEP, 8'h60);
		chk("balRst", 8'h00, {2'b00, balanceOut});
		chk("reqRst", 8'h01, {7'h00, addrUnassigned});
		$display("done reset");
	endtask : tReset
	task automatic tCells();
		logic [5:0] m;
		for (int c = 0; c < 8; c++) begin
			m = (c <= 5) ? 6'((1 << (c + 1)) - 1) : 6'h01;
			wr(OFF_CONVERSION_GO_SETUP, 8'(c * 9));
			chk("cells", {2'b00, m}, {2'b00, cellSelMask});
			chk("temp", {6'h00, 2'(c >> 1)}, {6'h00, tempInputSel});
			chk("aux", {7'h00, 1'(c)}, {7'h00, auxAnalogSel});
		end
		rx("setupRd", OFF_CONVERSION_GO_SETUP, 8'h3f);
		$display("done cells");
	endtask : tCells
	task automatic tConv();
		int n;
		wr(OFF_CONVERSION_GO_SETUP, 8'h05);
		chk("adcIdle", 8'h00, {7'h00, adcPowerOn});
		wr(OFF_CONVERSION_GO_TRIG, 8'h01);
		chk("adcWarm", 8'h01, {7'h00, adcPowerOn});
		n = 0;
		while (convStart !== 1'b1 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		chk("convGo", 8'h01, {7'h00, n > 300 && n < 1000});
		@(posedge core_clk);
		convDone <= 1'b1;
		@(posedge core_clk);
		convDone <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("adcOff", 8'h00, {7'h00, adcPowerOn});
		rx("goRd", OFF_CONVERSION_GO_TRIG, 8'h00);
		wr(OFF_CONVERSION_GO_SETUP, 8'h40);
		chk("adcOn", 8'h01, {7'h00, adcPowerOn});
		$display("done conversion");
	endtask : tConv
	task automatic tProt();
		wr(OFF_FUNC_CFG, 8'ha8);
		rx("locked", OFF_FUNC_CFG, 8'h00);
		wr(OFF_UNLOCK, KEY_UNLOCK);
		wr(OFF_FUNC_CFG, 8'ha8);
		rx("cfgRd", OFF_FUNC_CFG, 8'ha8);
		chk("speed", 8'h02, {6'h00, convSpeed});
		chk("refSrc", 8'h02, {6'h00, analogRefReg, analogSrcPack});
		chk("faultEn", 8'h0f, {2'b00, cellFaultEnable});
		rx("unlockRd", OFF_UNLOCK, 8'h00);
		wr(OFF_UNLOCK, KEY_UNLOCK);
		wr(OFF_CONVERSION_GO_SETUP, 8'h00);
		wr(OFF_FUNC_CFG, 8'h54);
		rx("keyUsed", OFF_FUNC_CFG, 8'ha8);
		otpReloadDone <= 1'b1;
		wr(OFF_UNLOCK, KEY_REFRESH);
		otpReloadDone <= 1'b0;
		rx("refresh", OFF_FUNC_CFG, 8'h5c);
		chk("refFault", 8'h07, {2'b00, cellFaultEnable});
		chk("reloadReq", 8'h01, 8'(reloadCnt));
		$display("done protected");
	endtask : tProt
	task automatic tBal();
		int n;
		wr(OFF_NODE_ID, 8'h85);
		host_u.nodeId = 6'h05;
		rx("idRd", OFF_NODE_ID, 8'h85);
		chk("addrReq", 8'h00, {7'h00, addrUnassigned});
		host_u.nodeId = ADDR_BROADCAST;
		for (int u = 0; u < 2; u++) begin
			wr(OFF_BAL_TIME, u ? 8'h81 : 8'h02);
			wr(OFF_BAL_EN, 8'h15);
			chk("balOn", 8'h15, {2'b00, balanceOut});
			n = 0;
			while (balanceOut !== 6'h00 && n < 3000) begin
				@(negedge core_clk);
				n++;
			end
			// Roughly a dozen cycles of the limit pass inside the write frame
			chk("balLimit", 8'h01, {7'h00, u ? n > 2340 && n < 2400 : n > 50 && n < 80});
		end
		wr(OFF_BAL_TIME, 8'h00);
		wr(OFF_BAL_EN, 8'h3f);
		chk("balZero", 8'h00, {2'b00, balanceOut});
		host_u.nodeId = 6'h05;
		$display("done balance");
	endtask : tBal
	task automatic tDebug();
		wr(OFF_DEBUG_SEL, KEY_DEBUG_1);
		wr(OFF_CONVERSION_GO_SETUP, 8'h00);
		wr(OFF_DEBUG_SEL, KEY_DEBUG_2);
		chk("dbgCancel", 8'h03, {6'h00, upperSclkOeN, upperSdiOeN});
		wr(OFF_DEBUG_SEL, KEY_DEBUG_1);
		wr(OFF_DEBUG_SEL, KEY_DEBUG_2);
		chk("dbgOn", 8'h00, {6'h00, upperSclkOeN, upperSdiOeN});
		linkRun = 1'b1;
		@(posedge lowerLinkClock);
		repeat (5) @(negedge core_clk);
		chk("passThru", 8'h02, {6'h00, upperSclkOut, upperSdiOut});
		linkRun = 1'b0;
		wr(OFF_DEBUG_SEL, KEY_NONE);
		chk("dbgOff", 8'h03, {6'h00, upperSclkOeN, upperSdiOeN});
		$display("done debug");
	endtask : tDebug
	task automatic tPins();
		wr(OFF_PIN_SLEEP, 8'h87);
		chk("pinOut", 8'h0b, {4'h0, supplySwitchOn, gpPinOeN, thermReturnSw});
		chk("sleep", 8'h02, {6'h00, lowPower, comparatorsOn});
		rx("pinLow", OFF_PIN_SLEEP, 8'h87);
		gpExt <= 1'b0;
		wr(OFF_PIN_SLEEP, 8'h40);
		chk("waking", 8'h00, {7'h00, comparatorsOn});
		rx("pinIn", OFF_PIN_SLEEP, 8'h40);
		chk("awake", 8'h01, {7'h00, comparatorsOn});
		$display("done pins");
	endtask : tPins
	task automatic tSoft();
		wr(OFF_OTP_EN, KEY_OTP);
		chk("otpOpen", 8'h01, {7'h00, otpWriteWindow});
		wr(OFF_SOFT_RST, 8'h11);
		chk("otpShut", 8'h00, {7'h00, otpWriteWindow});
		rx("rstIgnored", OFF_NODE_ID, 8'h85);
		wr(OFF_SOFT_RST, KEY_SOFT_RST);
		host_u.nodeId = 6'h00;
		rx("rstDone", OFF_NODE_ID, 8'h00);
		chk("rstReq", 8'h01, {7'h00, addrUnassigned});
		chk("softPulse", 8'h01, 8'(softCnt));
		$display("done soft reset");
	endtask : tSoft
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		tReset();
		tCells();
		tConv();
		tProt();
		tBal();
		tDebug();
		tPins();
		tSoft();
		final_report();
	end
	// About 13500 cycles expected; give the run 2 ms
	initial begin
		#2000000;
		err_count++;
		final_report();
	end
endmodule : monitor_control_register_bank_tb_top
